// File: shared/alu_logic_params.svh
/*
  Constants of the accumulator logic unit: widths, ranges and reset values.
  Assumes it is included by the package and the unit, and defines only macros.
*/
`ifndef ALU_LOGIC_PARAMS_SVH
`define ALU_LOGIC_PARAMS_SVH

`define ALU_ACC_W        32
`define ALU_WORD_W       16
`define ALU_RUN_MAX      32
`define ALU_CNT_W        6
`define ALU_ADDR_W       11
`define ALU_ACC_MSB      31
`define ALU_ACC_RESET    32'h0000_0000
`define ALU_WORD_ZERO    16'h0000
`define ALU_CNT_ZERO     6'h00
`define ALU_CNT_ONE      6'h01
`define ALU_CNT_MIN      6'h01
`define ALU_CNT_MAX      6'h20

`endif

// File: shared/alu_logic_pkg.sv
/*
  Types of the accumulator logic unit: operation codes, command carrier,
  sequencer states and the unit's complete state record.
  Assumes alu_logic_params.svh is on the include path.
*/
`default_nettype none

package alu_logic_pkg;
  `include "alu_logic_params.svh"

  typedef enum logic [3:0]
  {
    OP_AND_WORD,
    OP_OR_WORD,
    OP_XOR_WORD,
    and_wide_constant_op,
    or_wide_constant_op,
    exclusive_or_wide_constant_op,
    and_bit_run_op,
    or_bit_run_op,
    exclusive_or_bit_run_op
  } aluOp_t;

  typedef enum logic [1:0]
  {
    LOGIC_AND,
    LOGIC_OR,
    LOGIC_XOR
  } logicFn_t;

  typedef struct packed
  {
    logic                     valid;
    aluOp_t                   op;
    logic [`ALU_WORD_W-1:0]   wordData;
    logic [`ALU_ACC_W-1:0]    constData;
    logic [`ALU_ADDR_W-1:0]   bitStart;
    logic [`ALU_CNT_W-1:0]    bitCount;
  } aluCmd_t;

  typedef struct packed
  {
    logic                     valid;
    logic [`ALU_ACC_W-1:0]    value;
  } accLoad_t;

  typedef struct packed
  {
    logic                     zero;
    logic                     negative;
  } aluFlags_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_REQUEST,
    ST_CAPTURE
  } runState_t;

  typedef struct packed
  {
    runState_t                state;
    logic [`ALU_ACC_W-1:0]    acc;
    aluFlags_t                flags;
    logicFn_t                 fn;
    logic [`ALU_ADDR_W-1:0]   addr;
    logic [`ALU_CNT_W-1:0]    remain;
    logic [`ALU_CNT_W-1:0]    index;
    logic [`ALU_ACC_W-1:0]    gathered;
    logic                     readEn;
    logic                     done;
    logic                     error;
  } aluState_t;
endpackage

`default_nettype wire

// File: rtl/accumulator_logic_unit.sv
/*
  Accumulator logic unit: AND, OR and exclusive-OR of the accumulator with a
  word operand, a wide constant or a run of discrete memory bits, with the
  zero result flag and, for the constant and run forms, the negative result flag.
  Assumes the program sequencer on the same clock supplies word operands and
  constants with the command, and that the discrete memory answers a read
  one clock after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_logic_params.svh"

module accumulator_logic_unit
  import alu_logic_pkg::*;
#(
  parameter int unsigned ADDR_W  = `ALU_ADDR_W,
  parameter int unsigned RUN_MAX = `ALU_RUN_MAX
)
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire aluCmd_t                cmd,
  output logic                        cmdReady,
  input  wire accLoad_t               accLoad,
  output logic                        bitRdEn,
  output logic [`ALU_ADDR_W-1:0]      bitRdAddr,
  input  wire logic                   bitRdData,
  output logic [`ALU_ACC_W-1:0]       accValue,
  output logic                        zeroResultFlag,
  output logic                        negativeResultFlag,
  output logic                        opDone,
  output logic                        cmdError
);

  aluState_t state_q;
  aluState_t state_d;

  // Word forms only look at the low half; the operand is zero-extended.
  function automatic logic isWordOp(input aluOp_t op);
    isWordOp = (op == OP_AND_WORD) || (op == OP_OR_WORD) || (op == OP_XOR_WORD);
  endfunction

  function automatic logic isConstOp(input aluOp_t op);
    isConstOp = (op == and_wide_constant_op) || (op == or_wide_constant_op)
             || (op == exclusive_or_wide_constant_op);
  endfunction

  function automatic logic isRunOp(input aluOp_t op);
    isRunOp = (op == and_bit_run_op) || (op == or_bit_run_op)
           || (op == exclusive_or_bit_run_op);
  endfunction

  function automatic logicFn_t fnOf(input aluOp_t op);
    logicFn_t f;
    f = LOGIC_AND;
    unique case (op)
      OP_OR_WORD, or_wide_constant_op, or_bit_run_op:
        f = LOGIC_OR;
      OP_XOR_WORD, exclusive_or_wide_constant_op, exclusive_or_bit_run_op:
        f = LOGIC_XOR;
      default:
        f = LOGIC_AND;
    endcase
    fnOf = f;
  endfunction

  function automatic logic [`ALU_ACC_W-1:0] applyFn
  (
    input logicFn_t                f,
    input logic [`ALU_ACC_W-1:0]   a,
    input logic [`ALU_ACC_W-1:0]   b
  );
    logic [`ALU_ACC_W-1:0] r;
    r = a & b;
    unique case (f)
      LOGIC_AND:
        r = a & b;
      LOGIC_OR:
        r = a | b;
      LOGIC_XOR:
        r = a ^ b;
      default:
        r = a & b;
    endcase
    applyFn = r;
  endfunction

  // Mask of the bits that a run of the given length covers; bits above the
  // run take no part, so an AND of a short run clears the upper accumulator.
  logic [`ALU_ACC_W-1:0] runMask;

  genvar g;
  generate
    for (g = 0; g < `ALU_ACC_W; g++)
    begin : gen_mask
      assign runMask[g] = (state_q.index > `ALU_CNT_W'(g));
    end
  endgenerate

  logic [`ALU_ACC_W-1:0] wordFull;
  logic [`ALU_ACC_W-1:0] wordResult;
  logic [`ALU_ACC_W-1:0] constResult;
  logic                  pendingApply;
  logic [`ALU_ACC_W-1:0] runResult;
  logic [`ALU_ACC_W-1:0] runOperand;
  logic                  countOk;
  logic                  lastBit;

  always_comb
  begin
    wordFull    = applyFn(fnOf(cmd.op),
                          {`ALU_WORD_ZERO, state_q.acc[`ALU_WORD_W-1:0]},
                          {`ALU_WORD_ZERO, cmd.wordData});
    wordResult  = {`ALU_WORD_ZERO, wordFull[`ALU_WORD_W-1:0]};
    constResult = applyFn(fnOf(cmd.op), state_q.acc, cmd.constData);
    runOperand  = state_q.gathered & runMask;
    runResult   = applyFn(state_q.fn, state_q.acc, runOperand);
    countOk     = (cmd.bitCount >= `ALU_CNT_MIN)
               && (cmd.bitCount <= `ALU_CNT_W'(RUN_MAX));
    lastBit     = (state_q.remain == `ALU_CNT_ONE);
    // The cycle after the last captured bit still owes the run's result.
    pendingApply = (state_q.state == ST_IDLE) && (state_q.index != `ALU_CNT_ZERO)
                && !state_q.done && !state_q.error;
  end

  // Ready stays low while a run result is owed, otherwise a command taken
  // then would be computed from the old accumulator and then overwritten.
  assign cmdReady = (state_q.state == ST_IDLE) && !pendingApply;

  always_comb
  begin
    state_d        = state_q;
    state_d.done   = 1'b0;
    state_d.error  = 1'b0;
    state_d.readEn = 1'b0;
    unique case (state_q.state)
      ST_IDLE:
      begin
        if (pendingApply)
        begin
          state_d.state = ST_IDLE;
        end
        else if (cmd.valid && isWordOp(cmd.op))
        begin
          state_d.acc        = wordResult;
          state_d.flags.zero = (wordResult == `ALU_ACC_RESET);
          state_d.done       = 1'b1;
        end
        else if (cmd.valid && isConstOp(cmd.op))
        begin
          state_d.acc            = constResult;
          state_d.flags.zero     = (constResult == `ALU_ACC_RESET);
          state_d.flags.negative = constResult[`ALU_ACC_MSB];
          state_d.done           = 1'b1;
        end
        else if (cmd.valid && isRunOp(cmd.op) && countOk)
        begin
          state_d.fn       = fnOf(cmd.op);
          state_d.addr     = cmd.bitStart;
          state_d.remain   = cmd.bitCount;
          state_d.index    = `ALU_CNT_ZERO;
          state_d.gathered = `ALU_ACC_RESET;
          state_d.readEn   = 1'b1;
          state_d.state    = ST_REQUEST;
        end
        else if (cmd.valid && isRunOp(cmd.op))
        begin
          // A bad run length leaves the accumulator and both flags alone.
          state_d.error = 1'b1;
        end
        else if (accLoad.valid)
        begin
          state_d.acc = accLoad.value;
        end
      end
      ST_REQUEST:
      begin
        // The read strobe was issued for addr; its bit returns next cycle.
        state_d.state = ST_CAPTURE;
      end
      ST_CAPTURE:
      begin
        state_d.gathered[state_q.index[`ALU_CNT_W-2:0]] = bitRdData;
        state_d.index  = state_q.index + `ALU_CNT_ONE;
        state_d.remain = state_q.remain - `ALU_CNT_ONE;
        if (lastBit)
        begin
          state_d.state = ST_IDLE;
        end
        else
        begin
          state_d.addr   = state_q.addr + `ALU_ADDR_W'(1);
          state_d.readEn = 1'b1;
          state_d.state  = ST_REQUEST;
        end
      end
      default:
      begin
        state_d.state = ST_IDLE;
      end
    endcase

    // The result of a run is applied one cycle after the last bit lands, so
    // the mask and the gathered word are both stable when it is formed.
    if (pendingApply)
    begin
      state_d.acc            = runResult;
      state_d.flags.zero     = (runResult == `ALU_ACC_RESET);
      state_d.flags.negative = runResult[`ALU_ACC_MSB];
      state_d.index          = `ALU_CNT_ZERO;
      state_d.done           = 1'b1;
    end
  end

  // Flags are touched only by the operations above, so they persist between
  // updates.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign bitRdEn            = state_q.readEn;
  assign bitRdAddr          = state_q.addr;
  assign accValue           = state_q.acc;
  assign zeroResultFlag     = state_q.flags.zero;
  assign negativeResultFlag = state_q.flags.negative;
  assign opDone             = state_q.done;
  assign cmdError           = state_q.error;

endmodule

`default_nettype wire

// File: tb/accumulator_logic_unit_asserts.sv
/*
  Port checker of the accumulator logic unit.
  Assumes it is bound to the unit and shares its single clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module accumulator_logic_unit_asserts
  import alu_logic_pkg::*;
#(
  parameter int unsigned RUN_MAX = 32
)
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire aluCmd_t     cmd,
  input wire logic        cmdReady,
  input wire logic        bitRdEn,
  input wire logic [10:0] bitRdAddr,
  input wire logic [31:0] accValue,
  input wire logic        zeroResultFlag,
  input wire logic        negativeResultFlag,
  input wire logic        opDone,
  input wire logic        cmdError
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic tk = cmd.valid && cmdReady;
  wire logic wOp = cmd.op inside {OP_AND_WORD, OP_OR_WORD, OP_XOR_WORD};
  wire logic cOp = cmd.op inside {and_wide_constant_op, or_wide_constant_op,
    exclusive_or_wide_constant_op};
  wire logic rOp = tk && !wOp && !cOp;
  wire logic bad = cmd.bitCount == 6'h00 || cmd.bitCount > RUN_MAX;
  wire logic [31:0] b = wOp ? {16'h0000, cmd.wordData} : cmd.constData;
  wire logic [31:0] a = wOp ? {16'h0000, accValue[15:0]} : accValue;
  wire logic [31:0] r = cmd.op inside {OP_AND_WORD, and_wide_constant_op} ? a & b :
    cmd.op inside {OP_OR_WORD, or_wide_constant_op} ? a | b : a ^ b;
  sequence firstRead;
    ##1 bitRdEn && bitRdAddr == $past(cmd.bitStart) && !cmdReady;
  endsequence
  a_logic_result:
    assert property (tk && (wOp || cOp) |=> opDone && accValue == $past(r))
    else $error("logic result wrong");
  a_word_flags:
    assert property (tk && wOp |=> zeroResultFlag == (accValue == 32'h0)
      && negativeResultFlag == $past(negativeResultFlag)) else $error("word flags wrong");
  a_const_flags:
    assert property (tk && cOp |=> zeroResultFlag == (accValue == 32'h0)
      && negativeResultFlag == accValue[31]) else $error("constant flags wrong");
  a_done_zero:
    assert property (opDone |-> zeroResultFlag == (accValue == 32'h0))
    else $error("zero flag disagrees");
  a_run_steps:
    assert property (rOp && !bad |-> firstRead ##[2:65] opDone)
    else $error("bit run sequence wrong");
  a_bad_count:
    assert property (rOp && bad |=> cmdError && !opDone && $stable(accValue))
    else $error("bad count not refused");
  a_flags_hold:
    assert property (!opDone |-> $stable(zeroResultFlag) && $stable(negativeResultFlag))
    else $error("flags changed without an operation");
  a_busy_ready:
    assert property (bitRdEn |-> !cmdReady) else $error("ready while reading");
endmodule
bind accumulator_logic_unit accumulator_logic_unit_asserts #(.RUN_MAX(RUN_MAX)) chk_u (
  .core_clk(core_clk), .nrst(nrst), .cmd(cmd), .cmdReady(cmdReady), .bitRdEn(bitRdEn),
  .bitRdAddr(bitRdAddr), .accValue(accValue), .zeroResultFlag(zeroResultFlag),
  .negativeResultFlag(negativeResultFlag), .opDone(opDone), .cmdError(cmdError));
`default_nettype wire

// File: tb/accumulator_logic_unit_bench.sv
/*
  Self-checking bench of the accumulator logic unit.
  Assumes the checker file is compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module accumulator_logic_unit_bench
  import alu_logic_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  aluCmd_t cmd = '0;
  accLoad_t accLoad = '0;
  logic bitRdData = 1'b0;
  logic cmdReady, bitRdEn, zeroResultFlag, negativeResultFlag, opDone, cmdError;
  logic [10:0] bitRdAddr;
  logic [31:0] accValue, expAcc;
  logic expZ, expN;
  logic bitMem [0:2047];
  int n_errors = 0, checks_done = 0, cycles = 0;
  always #25 core_clk = ~core_clk;
  accumulator_logic_unit dut_u (.core_clk(core_clk), .nrst(nrst), .cmd(cmd),
    .cmdReady(cmdReady), .accLoad(accLoad), .bitRdEn(bitRdEn), .bitRdAddr(bitRdAddr),
    .bitRdData(bitRdData), .accValue(accValue), .zeroResultFlag(zeroResultFlag),
    .negativeResultFlag(negativeResultFlag), .opDone(opDone), .cmdError(cmdError));
  // Outside a read the line flips, so a stale bit never passes as fresh data.
  always @(posedge core_clk) bitRdData <= bitRdEn ? bitMem[bitRdAddr] : ~bitRdData;
  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (e !== g)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic load(logic [31:0] v);
    @(posedge core_clk);
    accLoad <= '{1'b1, v};
    @(posedge core_clk);
    accLoad.valid <= 1'b0;
    expAcc = v;
  endtask
  task automatic runOp(aluOp_t op, logic [31:0] arg, logic [10:0] st, logic [5:0] n);
    logic [31:0] b;
    b = arg;
    if (op >= and_bit_run_op)
    begin
      b = 32'h0;
      for (int k = 0; k < n; k++) b[k] = bitMem[st + k];
    end
    case (op)
      OP_AND_WORD: expAcc = {16'h0000, expAcc[15:0] & b[15:0]};
      OP_OR_WORD: expAcc = {16'h0000, expAcc[15:0] | b[15:0]};
      OP_XOR_WORD: expAcc = {16'h0000, expAcc[15:0] ^ b[15:0]};
      and_wide_constant_op, and_bit_run_op: expAcc = expAcc & b;
      or_wide_constant_op, or_bit_run_op: expAcc = expAcc | b;
      default: expAcc = expAcc ^ b;
    endcase
    expZ = expAcc == 32'h0;
    if (op > OP_XOR_WORD) expN = expAcc[31];
    @(posedge core_clk);
    cmd <= '{1'b1, op, arg[15:0], arg, st, n};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    repeat (80)
    begin
      @(negedge core_clk);
      if (opDone === 1'b1) break;
    end
    cmp("accValue", expAcc, accValue);
    cmp("zeroResultFlag", {31'h0, expZ}, {31'h0, zeroResultFlag});
    cmp("negativeResultFlag", {31'h0, expN}, {31'h0, negativeResultFlag});
  endtask
  task automatic badRun(logic [5:0] n);
    @(posedge core_clk);
    cmd <= '{1'b1, or_bit_run_op, 16'h0000, 32'h0, 11'h000, n};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    @(negedge core_clk);
    cmp("cmdError", 32'h1, {31'h0, cmdError});
    cmp("accValue", expAcc, accValue);
  endtask
  task automatic testConst();
    load(32'h7fff_ffff);
    runOp(or_wide_constant_op, 32'h8000_0000, 11'h000, 6'h00);
    runOp(exclusive_or_wide_constant_op, 32'hffff_ffff, 11'h000, 6'h00);
    runOp(and_wide_constant_op, 32'h3647_6a38, 11'h000, 6'h00);
    load(32'hc9b8_95c7);
    runOp(and_wide_constant_op, 32'hffff_ffff, 11'h000, 6'h00);
  endtask
  task automatic testWord();
    load(32'hdead_beef);
    runOp(OP_AND_WORD, 32'h0000_0000, 11'h000, 6'h00);
    runOp(OP_OR_WORD, 32'h0000_00a5, 11'h000, 6'h00);
    runOp(OP_XOR_WORD, 32'h0000_00a5, 11'h000, 6'h00);
  endtask
  task automatic testRun();
    load(32'hffff_ffff);
    runOp(and_bit_run_op, 32'h0, 11'h7e0, 6'h20);
    runOp(or_bit_run_op, 32'h0, 11'h005, 6'h01);
    runOp(exclusive_or_bit_run_op, 32'h0, 11'h010, 6'h04);
    badRun(6'h00);
    badRun(6'h21);
  endtask
  initial
  begin
    for (int i = 0; i < 2048; i++) bitMem[i] = i[0] ^ i[3];
    expAcc = 32'h0;
    expZ = 1'b0;
    expN = 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    testConst();
    testWord();
    testRun();
    finish_test();
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
endmodule
`default_nettype wire
